// ===== verilog/bsti_pkg.sv
package bsti_pkg;

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    localparam int        IR_W       = 3;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLE = 3'h2;
    localparam logic [2:0] IR_CLAMP  = 3'h3;
    localparam logic [2:0] IR_HIGHZ  = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPT   = 3'h1; // fixed capture pattern

    // ------------------------------------------------------------
    // identification register layout
    // ------------------------------------------------------------
    localparam int ID_W     = 32;
    localparam int ID_REV_W = 4;
    localparam int ID_DEV_W = 16;
    localparam int ID_MFR_W = 11;
    localparam logic ID_LSB = 1'h1; // required marker bit

    // ------------------------------------------------------------
    // test-access controller states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        TLR   = 16'h0001,
        RTI   = 16'h0002,
        SELDR = 16'h0004,
        CAPDR = 16'h0008,
        SHDR  = 16'h0010,
        EX1DR = 16'h0020,
        PSDR  = 16'h0040,
        EX2DR = 16'h0080,
        UPDR  = 16'h0100,
        SELIR = 16'h0200,
        CAPIR = 16'h0400,
        SHIR  = 16'h0800,
        EX1IR = 16'h1000,
        PSIR  = 16'h2000,
        EX2IR = 16'h4000,
        UPIR  = 16'h8000
    } bsti_tap_t;

    // boundary register selected by the instruction
    function automatic logic bsti_sel_bs(input logic [2:0] ir);
        bsti_sel_bs = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
    endfunction : bsti_sel_bs

    // outputs steered from the boundary latch
    function automatic logic bsti_drive(input logic [2:0] ir);
        bsti_drive = (ir == IR_EXTEST) || (ir == IR_CLAMP);
    endfunction : bsti_drive

endpackage : bsti_pkg

// ===== verilog/bsti_tap_fsm.sv
`timescale 1ns/10ps
`default_nettype none

module bsti_tap_fsm
    import bsti_pkg::*;
(
    input  wire logic tck,
    input  wire logic trst_n,
    input  wire logic tms,
    output var bsti_tap_t state
);

    typedef struct packed {
        bsti_tap_t tap;
    } bsti_fsm_st_t;

    bsti_fsm_st_t st;
    bsti_fsm_st_t next_st;

    assign state = st.tap;

    // ------------------------------------------------------------
    // next state from mode select
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        case (st.tap)
            TLR:     next_st.tap = tms ? TLR   : RTI;
            RTI:     next_st.tap = tms ? SELDR : RTI;
            SELDR:   next_st.tap = tms ? SELIR : CAPDR;
            CAPDR:   next_st.tap = tms ? EX1DR : SHDR;
            SHDR:    next_st.tap = tms ? EX1DR : SHDR;
            EX1DR:   next_st.tap = tms ? UPDR  : PSDR;
            PSDR:    next_st.tap = tms ? EX2DR : PSDR;
            EX2DR:   next_st.tap = tms ? UPDR  : SHDR;
            UPDR:    next_st.tap = tms ? SELDR : RTI;
            SELIR:   next_st.tap = tms ? TLR   : CAPIR;
            CAPIR:   next_st.tap = tms ? EX1IR : SHIR;
            SHIR:    next_st.tap = tms ? EX1IR : SHIR;
            EX1IR:   next_st.tap = tms ? UPIR  : PSIR;
            PSIR:    next_st.tap = tms ? EX2IR : PSIR;
            EX2IR:   next_st.tap = tms ? UPIR  : SHIR;
            UPIR:    next_st.tap = tms ? SELDR : RTI;
            default: next_st.tap = TLR;
        endcase
    end

    // controller starts in reset, test reset forces it back
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            st.tap <= TLR;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_tms_high5;
        tms [*5];
    endsequence

    chk_tms_reset: assert property (@(posedge tck) disable iff (!trst_n)
        s_tms_high5 |=> st.tap == TLR)
        else $error("five high mode-select edges did not reach reset");

    chk_shift_hold: assert property (@(posedge tck) disable iff (!trst_n)
        (st.tap == SHIR) && !tms |=> st.tap == SHIR)
        else $error("instruction shift left with mode select low");

    chk_exit_update: assert property (@(posedge tck) disable iff (!trst_n)
        (st.tap == EX1IR || st.tap == EX2IR) && tms |=> st.tap == UPIR)
        else $error("exit state with mode select high missed update");

endmodule : bsti_tap_fsm

`default_nettype wire

// ===== verilog/bsti_scan_top.sv
// Behaviour
// - three-bit instruction, shift stage plus latch
// - shift-IR puts instruction stage in path
// - falling edge entering update latches instruction
// - sample 010, extest 000, bypass 111
// - clamp 011, highz 100, idcode 001
// - sample captures pins, accepts shifted data
// - extest drives pins from boundary latch
// - bypass is one bit, no side effect
// - idcode loads id on capture, shifts out
// - reset state forces idcode into latch
// - highz floats outputs, bypass in path
// - clamp holds outputs from latch, bypass path
// - boundary chain covers control and pin cells
// - 32-bit id shift stage, no latch
// - id is revision, device, maker, one
// - controller samples mode select on rising edge
// - power-up starts controller in reset
`timescale 1ns/10ps
`default_nettype none

module bsti_scan_top
    import bsti_pkg::*;
#(
    parameter int                    N_IN   = 4,
    parameter int                    N_OUT  = 4,
    parameter logic [ID_REV_W-1:0]   ID_REV = 4'h0,     // arbitrary value
    parameter logic [ID_DEV_W-1:0]   ID_DEV = 16'h0001, // arbitrary value
    parameter logic [ID_MFR_W-1:0]   ID_MFR = 11'h001   // arbitrary value
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             test_clock_in,
    input  wire logic             test_reset_n,
    input  wire logic             test_mode_select,
    input  wire logic             test_serial_in,
    output logic                  test_serial_out,
    output logic                  test_serial_out_en,
    input  wire logic [N_IN-1:0]  pin_in,
    input  wire logic [N_OUT-1:0] core_out,
    input  wire logic [N_OUT-1:0] core_oe,
    output logic      [N_OUT-1:0] pin_out,
    output logic      [N_OUT-1:0] pin_oe
);

    // chain: inputs low, output data next, one control cell on top
    localparam int BS_W  = N_IN + N_OUT + 1;
    localparam int OUT_P = N_IN;
    localparam int CTL_P = N_IN + N_OUT;

    // identification value, marker bit at the bottom
    localparam logic [ID_W-1:0] ID_VAL = {ID_REV, ID_DEV, ID_MFR, ID_LSB};

    bsti_tap_t tap;

    // ------------------------------------------------------------
    // test-access controller
    // ------------------------------------------------------------
    bsti_tap_fsm u_fsm (
        .tck    (test_clock_in),
        .trst_n (test_reset_n),
        .tms    (test_mode_select),
        .state  (tap)
    );

    // ------------------------------------------------------------
    // rising-edge test state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [IR_W-1:0]  ir_sh;
        logic             byp;
        logic [ID_W-1:0]  id;
        logic [BS_W-1:0]  bs;
        logic [N_IN-1:0]  in_m;
        logic [N_IN-1:0]  in_s;
        logic [N_OUT-1:0] po_m;
        logic [N_OUT-1:0] po_s;
        logic             oe_m;
        logic             oe_s;
    } bsti_tp_t;

    // falling-edge test state
    typedef struct packed {
        logic [IR_W-1:0]  ir;
        logic [BS_W-1:0]  upd;
        logic             upd_tgl;
        logic             drive;
        logic             hiz;
        logic             tdo;
        logic             tdo_en;
    } bsti_tn_t;

    // system clock state
    typedef struct packed {
        logic             tgl_m;
        logic             tgl_s;
        logic             tgl_d;
        logic             drv_m;
        logic             drv_s;
        logic             hiz_m;
        logic             hiz_s;
        logic [N_OUT:0]   shadow;
        logic [N_OUT-1:0] pout;
        logic [N_OUT-1:0] poe;
    } bsti_ck_t;

    bsti_tp_t tp;
    bsti_tp_t next_tp;
    bsti_tn_t tn;
    bsti_tn_t next_tn;
    bsti_ck_t ck;
    bsti_ck_t next_ck;

    logic sel_bs;
    logic sel_id;

    // data-register selection from the current instruction
    assign sel_bs = bsti_sel_bs(tn.ir);
    assign sel_id = (tn.ir == IR_IDCODE);

    // ------------------------------------------------------------
    // capture and shift on the rising test clock
    // ------------------------------------------------------------
    always_comb begin
        next_tp = tp;
        // pin levels pass two stages before capture
        next_tp.in_m = pin_in;
        next_tp.in_s = tp.in_m;
        next_tp.po_m = ck.pout;
        next_tp.po_s = tp.po_m;
        next_tp.oe_m = ck.poe[0];
        next_tp.oe_s = tp.oe_m;
        case (tap)
            CAPIR: begin
                next_tp.ir_sh = IR_CAPT;
            end
            SHIR: begin
                next_tp.ir_sh = {test_serial_in, tp.ir_sh[IR_W-1:1]};
            end
            CAPDR: begin
                if (sel_bs) begin
                    next_tp.bs = {tp.oe_s, tp.po_s, tp.in_s};
                end else if (sel_id) begin
                    next_tp.id = ID_VAL;
                end else begin
                    next_tp.byp = 1'h0;
                end
            end
            SHDR: begin
                if (sel_bs) begin
                    next_tp.bs = {test_serial_in, tp.bs[BS_W-1:1]};
                end else if (sel_id) begin
                    next_tp.id = {test_serial_in, tp.id[ID_W-1:1]};
                end else begin
                    next_tp.byp = test_serial_in;
                end
            end
            default: begin
                next_tp.byp = tp.byp;
            end
        endcase
    end

    always_ff @(posedge test_clock_in or negedge test_reset_n) begin
        if (!test_reset_n) begin
            tp <= '0;
        end else begin
            tp <= next_tp;
        end
    end

    // ------------------------------------------------------------
    // update latches and serial out on the falling test clock
    // ------------------------------------------------------------
    always_comb begin
        next_tn = tn;
        if (tap == TLR) begin
            next_tn.ir = IR_IDCODE;
        end else if (tap == UPIR) begin
            next_tn.ir = tp.ir_sh;
        end
        if (tap == UPDR && sel_bs) begin
            next_tn.upd     = tp.bs;
            next_tn.upd_tgl = ~tn.upd_tgl;
        end
        // pin modes follow the instruction as it is latched
        next_tn.drive = bsti_drive(next_tn.ir);
        next_tn.hiz   = (next_tn.ir == IR_HIGHZ);
        // serial out changes only on this edge
        next_tn.tdo_en = (tap == SHIR) || (tap == SHDR);
        if (tap == SHIR) begin
            next_tn.tdo = tp.ir_sh[0];
        end else if (tap == SHDR) begin
            if (sel_bs) begin
                next_tn.tdo = tp.bs[0];
            end else if (sel_id) begin
                next_tn.tdo = tp.id[0];
            end else begin
                next_tn.tdo = tp.byp;
            end
        end else begin
            next_tn.tdo = 1'h0;
        end
    end

    always_ff @(negedge test_clock_in or negedge test_reset_n) begin
        if (!test_reset_n) begin
            tn    <= '0;
            tn.ir <= IR_IDCODE;
        end else begin
            tn <= next_tn;
        end
    end

    assign test_serial_out    = tn.tdo;
    assign test_serial_out_en = tn.tdo_en;

    // ------------------------------------------------------------
    // pin steering on the system clock
    // ------------------------------------------------------------
    // the update latch is stable while its toggle crosses over
    always_comb begin
        next_ck       = ck;
        next_ck.tgl_m = tn.upd_tgl;
        next_ck.tgl_s = ck.tgl_m;
        next_ck.tgl_d = ck.tgl_s;
        next_ck.drv_m = tn.drive;
        next_ck.drv_s = ck.drv_m;
        next_ck.hiz_m = tn.hiz;
        next_ck.hiz_s = ck.hiz_m;
        if (ck.tgl_s != ck.tgl_d) begin
            next_ck.shadow = tn.upd[CTL_P:OUT_P];
        end
        if (ck.hiz_s) begin
            next_ck.pout = core_out;
            next_ck.poe  = '0;
        end else if (ck.drv_s) begin
            next_ck.pout = ck.shadow[N_OUT-1:0];
            next_ck.poe  = {N_OUT{ck.shadow[N_OUT]}};
        end else begin
            next_ck.pout = core_out;
            next_ck.poe  = core_oe;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ck <= '0;
        end else begin
            ck <= next_ck;
        end
    end

    assign pin_out = ck.pout;
    assign pin_oe  = ck.poe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_ir_latch: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        tap == UPIR |-> tn.ir == tp.ir_sh)
        else $error("instruction latch differs from shift stage in update");

    chk_ir_reset: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        tap == TLR |-> tn.ir == IR_IDCODE)
        else $error("reset state without identification instruction");

    chk_ir_shift: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        tap == SHIR |=> tp.ir_sh == {$past(test_serial_in), $past(tp.ir_sh[2:1])})
        else $error("instruction stage did not shift one bit");

    chk_id_load: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        tap == CAPDR && tn.ir == IR_IDCODE |=> tp.id == ID_VAL)
        else $error("identification value not captured");

    sequence s_byp_shift;
        tap == SHDR && tn.ir == IR_BYPASS ##1 tap == SHDR;
    endsequence

    chk_byp_path: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        s_byp_shift |-> test_serial_out == $past(test_serial_in))
        else $error("bypass path is not one stage long");

    chk_tdo_float: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        test_serial_out_en == (tap == SHIR || tap == SHDR))
        else $error("serial out enable outside shift states");

    chk_highz_pin: assert property (@(posedge clk) disable iff (!nrst)
        ck.hiz_s |=> pin_oe == '0)
        else $error("outputs driven under highz");

    chk_clamp_hold: assert property (@(posedge clk) disable iff (!nrst)
        ck.drv_s && !ck.hiz_s ##1 ck.drv_s && !ck.hiz_s && $stable(ck.shadow)
        |-> pin_out == ck.shadow[N_OUT-1:0])
        else $error("driven pins do not follow the boundary latch");

    chk_normal_pin: assert property (@(posedge clk) disable iff (!nrst)
        !ck.drv_s && !ck.hiz_s |=> pin_out == $past(core_out))
        else $error("normal pin path disturbed");

    // ------------------------------------------------------------
    // data-register scan checks
    // ------------------------------------------------------------
    sequence s_bs_capture;
        tap == CAPDR && sel_bs;
    endsequence

    sequence s_bs_shift;
        tap == SHDR && sel_bs;
    endsequence

    sequence s_bs_update;
        tap == UPDR && sel_bs;
    endsequence

    chk_bs_capture: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        s_bs_capture |=> tp.bs == $past({tp.oe_s, tp.po_s, tp.in_s}))
        else $error("boundary stage did not capture pins and outputs");

    chk_bs_shift: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        s_bs_shift |=> tp.bs == {$past(test_serial_in), $past(tp.bs[BS_W-1:1])})
        else $error("boundary stage did not shift one bit");

    chk_bs_update: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        s_bs_update |-> tn.upd == tp.bs)
        else $error("boundary latch differs from shift stage in update");

    chk_id_shift: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        tap == SHDR && sel_id |=> tp.id == {$past(test_serial_in), $past(tp.id[ID_W-1:1])})
        else $error("identification stage did not shift one bit");

    chk_ir_hold: assert property (@(posedge test_clock_in)
        disable iff (!test_reset_n)
        tap != UPIR && tap != TLR |-> $stable(tn.ir))
        else $error("instruction latch changed outside update and reset");

endmodule : bsti_scan_top

`default_nettype wire

// ===== test/bsti_tester_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// external tester: test clock only runs inside frames
// ------------------------------------------------------------
module bsti_tester_model (
    output logic      tck,
    output logic      trst_n,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_en
);
    logic en_ok;
    logic last_en;

    // idle levels at time zero, reset held
    initial begin
        tck = 1'b0;
        trst_n = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        en_ok = 1'b1;
        last_en = 1'b0;
    end

    // test reset level, acts without a clock
    task automatic set_trst(input logic v);
        trst_n = v;
    endtask : set_trst

    // one test clock cycle, clock rests low afterwards
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #16;
        q = tdo; // shown since the last falling edge
        last_en = tdo_en;
        #16 tck = 1'b1;
        #32 tck = 1'b0;
    endtask : tick

    // control step; serial in toggles so no stale value is shown
    task automatic ctl(input logic m);
        logic q;
        tick(m, ~tdi, q);
    endtask : ctl

    // five high mode-select edges reach reset from anywhere
    task automatic reset5();
        repeat (5) ctl(1'b1);
        ctl(1'b0);
    endtask : reset5

    // full scan from idle: two idle edges let the pin syncs settle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic q;
        dout = '0;
        ctl(1'b0);
        ctl(1'b0);
        ctl(1'b1);
        if (ir) ctl(1'b1);
        ctl(1'b0);
        ctl(1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
            if (last_en !== 1'b1) en_ok = 1'b0;
        end
        ctl(1'b1); // leave exit for update
        ctl(1'b0);
    endtask : scan
endmodule : bsti_tester_model

`default_nettype wire

// ===== test/boundary_scan_instruction_and_test_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

module boundary_scan_instruction_and_test_regs_tb;
    import bsti_pkg::*;

    localparam logic [3:0]  ID_R = 4'h0;     // arbitrary value
    localparam logic [15:0] ID_D = 16'h0001; // arbitrary value
    localparam logic [10:0] ID_M = 11'h001;  // arbitrary value
    localparam logic [63:0] ID_V = {32'h0, ID_R, ID_D, ID_M, 1'h1};

    logic        clk;
    logic        nrst;
    wire         tck;
    wire         trst_n;
    wire         tms;
    wire         tdi;
    wire         tdo;
    wire         tdo_en;
    logic [3:0]  pin_in;
    logic [3:0]  core_out;
    logic [3:0]  core_oe;
    wire  [3:0]  pin_out;
    wire  [3:0]  pin_oe;
    int          miscompares;
    int          tests_run;
    int          cycles;
    logic [2:0]  cur_ir;
    logic [8:0]  latch;
    logic [15:0] rnd;
    logic [63:0] dout;
    logic [2:0]  codes [6];

    bsti_scan_top #(.N_IN(4), .N_OUT(4), .ID_REV(ID_R), .ID_DEV(ID_D), .ID_MFR(ID_M)) uut (
        .clk(clk), .nrst(nrst), .test_clock_in(tck), .test_reset_n(trst_n),
        .test_mode_select(tms), .test_serial_in(tdi), .test_serial_out(tdo),
        .test_serial_out_en(tdo_en), .pin_in(pin_in), .core_out(core_out),
        .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));

    bsti_tester_model u_tst (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
                             .tdo(tdo), .tdo_en(tdo_en));

    // ------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    // serial model of a w-bit scan register: captured bits leave first, LSB first
    function automatic logic [63:0] model_out(input logic [63:0] cap, input int w, input int n,
                                              input logic [63:0] din);
        logic q[$];
        model_out = '0;
        for (int i = 0; i < w; i++) begin
            q.push_back(cap[i]);
        end
        for (int i = 0; i < n; i++) begin
            model_out[i] = q.pop_front();
            q.push_back(din[i]);
        end
    endfunction : model_out

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // expected pads {oe, out} from the current mode and boundary latch
    function automatic logic [7:0] exp_pins();
        case (cur_ir)
            IR_EXTEST, IR_CLAMP: exp_pins = {{4{latch[8]}}, latch[7:4]};
            IR_HIGHZ: exp_pins = {4'h0, core_out};
            default: exp_pins = {core_oe, core_out};
        endcase
    endfunction : exp_pins

    task automatic check_pins();
        repeat (10) @(negedge clk);
        check("pins", 64'({pin_oe, pin_out}), 64'(exp_pins()));
    endtask : check_pins

    task automatic set_pins();
        @(negedge clk);
        rnd = lfsr(rnd);
        pin_in = rnd[3:0];
        core_out = rnd[7:4];
        core_oe = rnd[11:8];
        repeat (4) @(negedge clk);
    endtask : set_pins

    task automatic ir_load(input logic [2:0] code);
        u_tst.scan(1'b1, 3, 64'(code), dout);
        check("ir_capture", dout, model_out(64'(IR_CAPT), 3, 3, 64'(code)));
        cur_ir = code;
    endtask : ir_load

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        pin_in = 4'h0;
        core_out = 4'h0;
        core_oe = 4'h0;
        miscompares = 0;
        tests_run = 0;
        cycles = 0;
        rnd = 16'h0003;
        cur_ir = IR_IDCODE;
        latch = 9'h000;
        codes = '{IR_SAMPLE, IR_EXTEST, IR_CLAMP, IR_HIGHZ, IR_BYPASS, IR_IDCODE};
        repeat (10) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        u_tst.set_trst(1'b1);
        u_tst.scan(1'b0, 32, 64'h0, dout);
        check("id_after_reset", dout, ID_V);
        check("idle_en", 64'(tdo_en), 64'h0);
        $display("test reset_id done");
        for (int k = 0; k < 6; k++) begin
            logic [63:0] din;
            logic [63:0] exp;
            logic [7:0]  ep;
            logic [63:0] cap;
            int          n;
            int          w;
            set_pins();
            ir_load(codes[k]);
            check_pins();
            set_pins();
            rnd = lfsr(rnd);
            din = 64'(rnd);
            ep = exp_pins();
            if (cur_ir == IR_SAMPLE || cur_ir == IR_EXTEST) begin
                w = 9;
                cap = 64'({ep[4], ep[3:0], pin_in});
            end else if (cur_ir == IR_IDCODE) begin
                w = 32;
                cap = ID_V;
            end else begin
                w = 1;
                cap = 64'h0;
            end
            n = (w == 1) ? 8 : w;
            exp = model_out(cap, w, n, din);
            u_tst.scan(1'b0, n, din, dout);
            check("dr_out", dout, exp);
            if (n == 9) latch = din[8:0];
            check_pins();
            $display("test code %0d done", codes[k]);
        end
        check("shift_en", 64'(u_tst.en_ok), 64'h1);
        ir_load(IR_BYPASS);
        u_tst.reset5();
        cur_ir = IR_IDCODE;
        u_tst.scan(1'b0, 32, 64'h0, dout);
        check("id_after_tms", dout, ID_V);
        ir_load(IR_BYPASS);
        u_tst.set_trst(1'b0);
        #100;
        u_tst.set_trst(1'b1);
        cur_ir = IR_IDCODE;
        u_tst.scan(1'b0, 32, 64'h0, dout);
        check("id_after_trst", dout, ID_V);
        $display("test return_to_reset done");
        end_sim();
    end
endmodule : boundary_scan_instruction_and_test_regs_tb

`default_nettype wire
